// ===== hw/btsb_exec.sv
// Execution unit for bit-test skips and status flag branches.
// Assumes register and I/O reads answer combinationally on the same clock.
// What this block does
// - Register bit one skips next instruction, PC plus two or three, flags untouched.
// - I/O register bit zero skips next instruction, PC plus two or three, no flags.
// - I/O register bit one skips next instruction, PC plus two or three, no flags.
// - Chosen status flag one loads PC with PC plus offset plus one.
// - Chosen status flag zero loads PC with PC plus offset plus one.
`timescale 1ns/1ps
module btsb_exec
  import btsb_pkg::*;
(
  input  wire logic                  MCLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  INSTR_VALID,
  input  wire btsb_instr_t           INSTR,
  output logic                       INSTR_READY,
  output logic [GPR_ADDR_W-1:0]      GPR_ADDR,
  input  wire logic [7:0]            GPR_DATA,
  output logic [IO_ADDR_W-1:0]       IO_ADDR,
  input  wire logic [7:0]            IO_DATA,
  input  wire logic [7:0]            STATUS_FLAGS,
  output logic [PC_W-1:0]            PC,
  output logic                       DONE,
  output logic                       TAKEN,
  output logic [1:0]                 CYCLES
);

  // Whole state of the unit in one struct, registered in one place
  btsb_regs_t           r_reg;
  btsb_regs_t           r_next;

  // Decode results, all combinational from the presented instruction
  logic                 accept;
  logic                 cond;
  logic                 is_br;
  logic [PC_W-1:0]      pc_step;
  logic [1:0]           cost;
  logic [1:0]           extra;

  // Selects one bit of an 8-bit value by the bit-select operand
  function automatic logic pick_bit(
    input logic [7:0]       v,
    input logic [SEL_W-1:0] s
  );
    pick_bit = v[s];
  endfunction

  // True for the two flag branches
  function automatic logic is_branch(input btsb_op_t o);
    is_branch = (o == BTSB_OP_BRANCH_FLAG_SET) ||
                (o == BTSB_OP_BRANCH_FLAG_CLEAR);
  endfunction

  // True for the three bit-test skips
  function automatic logic is_skip(input btsb_op_t o);
    is_skip = (o == BTSB_OP_SKIP_REG_BIT_SET) ||
              (o == BTSB_OP_SKIP_IO_BIT_CLEAR) ||
              (o == BTSB_OP_SKIP_IO_BIT_SET);
  endfunction

  // Offset is two's complement; widen by its sign bit so backward branches wrap
  function automatic logic [PC_W-1:0] sext_off(input logic [OFF_W-1:0] k);
    sext_off = {{(PC_W-OFF_W){k[OFF_W-1]}}, k};
  endfunction

  // Words jumped by a taken skip, which is also its cycle cost
  function automatic logic [1:0] skip_words(input logic two);
    if (two) begin
      skip_words = 2'(SKIP_TWO_WD);
    end else begin
      skip_words = 2'(SKIP_ONE_WD);
    end
  endfunction

  // Operand addresses go straight out so the register files answer in the same cycle
  assign GPR_ADDR    = INSTR.gpr_addr;
  assign IO_ADDR     = INSTR.io_addr;
  assign INSTR_READY = (r_reg.state == BTSB_ST_IDLE);

  // An empty slot is not an instruction and must not move the counter
  assign accept = INSTR_VALID &&
                  (r_reg.state == BTSB_ST_IDLE) &&
                  (INSTR.op != BTSB_OP_NONE);

  always_comb begin
    cond = 1'b0;
    case (INSTR.op)
      BTSB_OP_SKIP_REG_BIT_SET: begin
        cond = pick_bit(GPR_DATA, INSTR.bit_sel);
      end
      BTSB_OP_SKIP_IO_BIT_CLEAR: begin
        cond = !pick_bit(IO_DATA, INSTR.bit_sel);
      end
      BTSB_OP_SKIP_IO_BIT_SET: begin
        cond = pick_bit(IO_DATA, INSTR.bit_sel);
      end
      BTSB_OP_BRANCH_FLAG_SET: begin
        cond = pick_bit(STATUS_FLAGS, INSTR.bit_sel);
      end
      BTSB_OP_BRANCH_FLAG_CLEAR: begin
        cond = !pick_bit(STATUS_FLAGS, INSTR.bit_sel);
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // Counter step and cost; a false condition always costs one cycle and one word
  always_comb begin
    is_br   = is_branch(INSTR.op);
    pc_step = PC_W'(1);
    cost    = 2'(CYC_FALSE);
    extra   = 2'd0;
    if (cond) begin
      if (is_br) begin
        pc_step = sext_off(INSTR.offset) + PC_W'(1);
        cost    = 2'(CYC_BRANCH);
      end else if (is_skip(INSTR.op)) begin
        pc_step = PC_W'(skip_words(INSTR.next_two_words));
        cost    = skip_words(INSTR.next_two_words);
      end
      extra = cost - 2'd1;
    end
  end

  // Status flags are only read here, never written, so no flag side effect exists
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    case (r_reg.state)
      BTSB_ST_IDLE: begin
        if (accept) begin
          r_next.pc     = r_reg.pc + pc_step;
          r_next.taken  = cond;
          r_next.cycles = cost;
          if (cond) begin
            // Taken paths stall the core for the extra cycles before reporting
            r_next.state    = BTSB_ST_WAIT;
            r_next.wait_cnt = extra - 2'd1;
          end else begin
            r_next.done = 1'b1;
          end
        end
      end
      BTSB_ST_WAIT: begin
        if (r_reg.wait_cnt == 2'd0) begin
          r_next.state = BTSB_ST_IDLE;
          r_next.done  = 1'b1;
        end else begin
          r_next.wait_cnt = r_reg.wait_cnt - 2'd1;
        end
      end
      default: begin
        r_next.state = BTSB_ST_IDLE;
      end
    endcase
  end

  // Synchronous reset; the core restarts from the reset vector and reports nothing
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r_reg <= '{
        state:    BTSB_ST_IDLE,
        pc:       PC_RESET,
        wait_cnt: 2'd0,
        done:     1'b0,
        taken:    1'b0,
        cycles:   2'd0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  assign PC     = r_reg.pc;
  assign DONE   = r_reg.done;
  assign TAKEN  = r_reg.taken;
  assign CYCLES = r_reg.cycles;

endmodule

// ===== hw/btsb_pkg.sv
// Package for the bit-test skip and flag branch execution unit.
// Assumes a core that presents one decoded instruction at a time.
package btsb_pkg;
  localparam int PC_W        = 16;
  localparam int OFF_W       = 7;
  localparam int SEL_W       = 3;
  localparam int IO_ADDR_W   = 6;
  localparam int GPR_ADDR_W  = 5;
  localparam int SKIP_ONE_WD = 2;
  localparam int SKIP_TWO_WD = 3;
  localparam int CYC_FALSE   = 1;
  localparam int CYC_BRANCH  = 2;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

  typedef enum logic [2:0] {
    BTSB_OP_NONE,
    BTSB_OP_SKIP_REG_BIT_SET,
    BTSB_OP_SKIP_IO_BIT_CLEAR,
    BTSB_OP_SKIP_IO_BIT_SET,
    BTSB_OP_BRANCH_FLAG_SET,
    BTSB_OP_BRANCH_FLAG_CLEAR
  } btsb_op_t;

  typedef enum logic [1:0] {
    BTSB_ST_IDLE,
    BTSB_ST_WAIT
  } btsb_state_t;

  // One decoded instruction as the core hands it over
  typedef struct packed {
    btsb_op_t               op;
    logic [SEL_W-1:0]       bit_sel;
    logic [IO_ADDR_W-1:0]   io_addr;
    logic [GPR_ADDR_W-1:0]  gpr_addr;
    logic signed [OFF_W-1:0] offset;
    logic                   next_two_words;
  } btsb_instr_t;

  typedef struct packed {
    btsb_state_t      state;
    logic [PC_W-1:0]  pc;
    logic [1:0]       wait_cnt;
    logic             done;
    logic             taken;
    logic [1:0]       cycles;
  } btsb_regs_t;
endpackage

// ===== verif/btsb_exec_asserts.sv
// Port checks of the skip and branch unit.
// Bound onto btsb_exec; sees its ports only.
`timescale 1ns/1ps
module btsb_exec_asserts import btsb_pkg::*; (
  input wire logic MCLK, SYS_RST, INSTR_VALID, INSTR_READY, DONE, TAKEN,
  input wire btsb_instr_t INSTR,
  input wire logic [7:0] GPR_DATA, IO_DATA, STATUS_FLAGS,
  input wire logic [15:0] PC,
  input wire logic [1:0] CYCLES);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  wire go = INSTR_VALID && INSTR_READY;
  wire w = INSTR.next_two_words;
  wire [2:0] s = INSTR.bit_sel;
  btsb_op_t op;
  assign op = INSTR.op;
  property p_reg;
    go && op == BTSB_OP_SKIP_REG_BIT_SET && GPR_DATA[s]
    |=> TAKEN && PC == $past(PC) + ($past(w) ? 16'h3 : 16'h2);
  endproperty
  a_reg: assert property (p_reg) else $error("reg skip");
  property p_ioc;
    go && op == BTSB_OP_SKIP_IO_BIT_CLEAR && !IO_DATA[s]
    |=> TAKEN && CYCLES == ($past(w) ? 2'h3 : 2'h2);
  endproperty
  a_ioc: assert property (p_ioc) else $error("io clear");
  property p_ios;
    go && op == BTSB_OP_SKIP_IO_BIT_SET && IO_DATA[s] && w
    |=> !DONE [*2] ##1 DONE;
  endproperty
  a_ios: assert property (p_ios) else $error("io set");
  property p_brs;
    go && op == BTSB_OP_BRANCH_FLAG_SET && STATUS_FLAGS[s]
    |=> PC == $past(PC) + 16'($past(INSTR.offset)) + 16'h1;
  endproperty
  a_brs: assert property (p_brs) else $error("branch set");
  property p_brc;
    go && op == BTSB_OP_BRANCH_FLAG_CLEAR && !STATUS_FLAGS[s]
    |=> TAKEN && CYCLES == 2'h2 ##1 DONE;
  endproperty
  a_brc: assert property (p_brc) else $error("branch clear");
  property p_any;
    go && op != BTSB_OP_NONE
    |=> TAKEN || DONE && CYCLES == 2'h1 && PC == $past(PC) + 16'h1;
  endproperty
  a_any: assert property (p_any) else $error("untaken");
endmodule
bind btsb_exec btsb_exec_asserts btsb_exec_asserts_i (.*);

// ===== verif/btsb_exec_tb.sv
// Directed bench of the skip and branch unit.
// Drives every port itself at the rising edge.
`timescale 1ns/1ps
module btsb_exec_tb import btsb_pkg::*;;
  logic MCLK = 0, SYS_RST = 1, INSTR_VALID = 0, INSTR_READY, DONE, TAKEN;
  btsb_instr_t INSTR = '0;
  logic [7:0] GPR_DATA = 0, IO_DATA = 0, STATUS_FLAGS = 0;
  logic [15:0] PC;
  logic [1:0] CYCLES;
  logic [4:0] GPR_ADDR;
  logic [5:0] IO_ADDR;
  int num_errors = 0, total_checks = 0;
  btsb_exec btsb_exec_i (.*);
  always #4 MCLK = ~MCLK;
  task automatic wrap_up;
    $display("%0d checks %0d errors", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(bit bad);
    total_checks++;
    if (bad) begin
      num_errors++;
      $display("unexpected %0t bad result", $time);
    end
  endtask
  task automatic run(btsb_op_t o, logic [2:0] s, logic [7:0] v, logic w, logic [6:0] k, logic [15:0] d, int c);
    logic [15:0] p;
    int n = 1;
    p = PC;
    @(posedge MCLK);
    INSTR <= '{o, s, 6'h2a, 5'h15, k, w};
    {GPR_DATA, IO_DATA, STATUS_FLAGS} <= {3{v}};
    INSTR_VALID <= 1;
    @(posedge MCLK);
    INSTR_VALID <= 0;
    #1;
    check(GPR_ADDR !== 5'h15 || IO_ADDR !== 6'h2a || INSTR_READY !== (c == 1));
    // Edges counted up to DONE give the cost
    while (DONE !== 1 && n < 5) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    check(n != c || CYCLES !== c[1:0] || TAKEN !== (c > 1) || PC !== p + d);
  endtask
  task automatic t_refuse;
    logic [15:0] p;
    p = PC;
    @(posedge MCLK);
    INSTR <= '{BTSB_OP_NONE, 3'h0, 6'h0, 5'h0, 7'h0, 1'b0};
    INSTR_VALID <= 1;
    @(posedge MCLK);
    INSTR <= '{BTSB_OP_SKIP_REG_BIT_SET, 3'h0, 6'h0, 5'h0, 7'h0, 1'b1};
    GPR_DATA <= 8'h01;
    #1;
    check(DONE !== 0 || PC !== p || INSTR_READY !== 1);
    @(posedge MCLK);
    INSTR <= '{BTSB_OP_BRANCH_FLAG_SET, 3'h0, 6'h0, 5'h0, 7'h10, 1'b0};
    STATUS_FLAGS <= 8'h01;
    #1;
    check(PC !== p + 16'h3 || INSTR_READY !== 0 || DONE !== 0);
    @(posedge MCLK);
    INSTR_VALID <= 0;
    #1;
    check(DONE !== 0 || PC !== p + 16'h3);
    @(posedge MCLK);
    #1;
    check(DONE !== 1 || PC !== p + 16'h3 || CYCLES !== 2'h3);
  endtask
  task automatic t_skip;
    run(BTSB_OP_SKIP_REG_BIT_SET, 5, 8'h20, 1, 0, 3, 3);
    run(BTSB_OP_SKIP_REG_BIT_SET, 0, 8'h01, 0, 0, 2, 2);
    run(BTSB_OP_SKIP_REG_BIT_SET, 0, 8'hfe, 1, 0, 1, 1);
    run(BTSB_OP_SKIP_IO_BIT_CLEAR, 0, 8'hfe, 0, 0, 2, 2);
    run(BTSB_OP_SKIP_IO_BIT_SET, 7, 8'h80, 1, 0, 3, 3);
    run(BTSB_OP_SKIP_IO_BIT_SET, 7, 8'h7f, 0, 0, 1, 1);
  endtask
  task automatic t_branch;
    run(BTSB_OP_BRANCH_FLAG_SET, 1, 8'h02, 0, 7'h7c, -3, 2);
    run(BTSB_OP_BRANCH_FLAG_CLEAR, 6, 8'hbf, 0, 7'h3f, 64, 2);
    run(BTSB_OP_BRANCH_FLAG_CLEAR, 6, 8'h40, 0, 0, 1, 1);
  endtask
  initial begin
    repeat (4) @(posedge MCLK);
    SYS_RST <= 0;
    t_skip();
    t_branch();
    t_refuse();
    wrap_up();
  end
  initial begin
    #2000;
    num_errors++;
    wrap_up();
  end
endmodule
